// file: eesq_arb.sv
// Fixed priority arbiter and coprocessor trap decode
`timescale 1ns/1ps
module eesq_arb
    import eesq_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    eesq_exc_if.arb   exc
);
    function automatic logic cop_undef(input logic [31:0] w, input logic [4:0] m);
        logic xfer;
        logic other;
        logic user;
        xfer  = (w[27:24] == 4'he) && w[4];
        other = ((w[27:24] == 4'he) && !w[4]) || (w[27:25] == 3'h6);
        user  = (m == MODE_USR) || (m == MODE_USR26);
        return other || (xfer && ((w[11:8] != CP_CTRL) || user));
    endfunction : cop_undef

    logic und_req;
    logic swi_req;

    always_comb begin
        und_req = exc.undef || cop_undef(exc.instr, exc.mode);
        swi_req = (exc.instr[27:24] == 4'hf);
    end

    always_comb begin
        exc.win = EXC_NONE;
        if (exc.dabt) begin
            exc.win = EXC_DABT;
        end else if (exc.fast && (exc.boundary || exc.chain)) begin
            exc.win = EXC_FAST;
        end else if (exc.irq && exc.boundary) begin
            exc.win = EXC_IRQ;
        end else if (exc.pabt && exc.boundary) begin
            exc.win = EXC_PABT;
        end else if (exc.boundary && und_req) begin
            exc.win = EXC_UND;
        end else if (exc.boundary && swi_req) begin
            exc.win = EXC_SWI;
        end
    end

    a_dabt_first: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        exc.dabt |-> exc.win == EXC_DABT)
        else $error("data abort lost priority");
    a_cop_trap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (exc.boundary && !exc.dabt && !exc.fast && !exc.irq && !exc.pabt && exc.instr[27:24] == 4'he
         && exc.instr[11:8] != CP_CTRL) |-> exc.win == EXC_UND)
        else $error("coprocessor access not trapped");
endmodule : eesq_arb

// file: eesq_exc_if.sv
// Carrier between the sequencer core and its priority arbiter
`timescale 1ns/1ps
interface eesq_exc_if;
    import eesq_pkg::*;
    logic        dabt;
    logic        fast;
    logic        irq;
    logic        pabt;
    logic        boundary;
    logic        chain;
    logic        undef;
    logic [31:0] instr;
    logic [4:0]  mode;
    eesq_exc_t   win;
    modport arb (input dabt, fast, irq, pabt, boundary, chain, undef, instr, mode, output win);
    modport core (output dabt, fast, irq, pabt, boundary, chain, undef, instr, mode, input win);
endinterface : eesq_exc_if

// file: eesq_fetch_model.sv
// Fetch unit model that follows redirects and steps through sequential fetches
`timescale 1ns/1ps
module eesq_fetch_model (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        redirect_i,
    input  wire logic [31:0] redirect_addr_i,
    input  wire logic        bus_enable_i,
    output logic      [31:0] fetch_addr_o
);
    // Parks one word below zero, so a step without a redirect also reaches the reset vector
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fetch_addr_o <= 32'hffff_fffc;
        end else if (redirect_i) begin
            fetch_addr_o <= redirect_addr_i;
        end else if (bus_enable_i) begin
            fetch_addr_o <= fetch_addr_o + 32'h4;
        end
    end
endmodule : eesq_fetch_model

// file: eesq_pkg.sv
// Constants and types for the exception entry sequencer
// Functional notes
// - Enter exceptions in 32-bit mode, no merging
// - Save PC and status into target bank
// - Reset low: stop, assert reset out, idle
// - Release copies PC and status to supervisor
// - Release forces supervisor mode, both masks set
// - First fetch after release from zero
// - Reset disables caches, MMU, alignment, big endian
// - Sample MMU and pin aborts during accesses
// - Prefetch abort tags instruction, raised at execute
// - Single word abort leaves registers unmodified
// - Swap abort leaves state as never executed
// - Block abort: no writeback, base restored
// - Abort link gets PC plus 4 or 8
// - Abort entry forces abort mode, sets I
// - Prefetch abort vector 0x0C, data 0x10
// - Other vectors: undef, swi, irq, fast
// - Fixed priority among simultaneous exceptions
// - Data abort then immediate unmasked fast interrupt
// - Coprocessor other than 15 is undefined
// - Coprocessor load, store, data op undefined
// - Control coprocessor transfers need privileged mode
package eesq_pkg;
    localparam logic [4:0]  MODE_USR26     = 5'h00;
    localparam logic [4:0]  MODE_USR       = 5'h10;
    localparam logic [4:0]  MODE_FAST      = 5'h11;
    localparam logic [4:0]  MODE_IRQ       = 5'h12;
    localparam logic [4:0]  MODE_SVC       = 5'h13;
    localparam logic [4:0]  MODE_ABT       = 5'h17;
    localparam logic [4:0]  MODE_UND       = 5'h1b;
    localparam int          ST_I_BIT       = 7;
    localparam int          ST_F_BIT       = 6;
    localparam int          ST_M32_BIT     = 4;
    localparam logic [31:0] STATUS_RST     = 32'h0000_00d3;
    localparam logic [31:0] VEC_RST        = 32'h0000_0000;
    localparam logic [31:0] VEC_UND        = 32'h0000_0004;
    localparam logic [31:0] VEC_SWI        = 32'h0000_0008;
    localparam logic [31:0] VEC_PABT       = 32'h0000_000c;
    localparam logic [31:0] VEC_DABT       = 32'h0000_0010;
    localparam logic [31:0] VEC_IRQ        = 32'h0000_0018;
    localparam logic [31:0] VEC_FAST       = 32'h0000_001c;
    localparam logic [31:0] LINK_OFS_PABT  = 32'h0000_0004;
    localparam logic [31:0] LINK_OFS_DABT  = 32'h0000_0008;
    localparam logic [31:0] LINK_OFS_OTHER = 32'h0000_0004;
    localparam logic [3:0]  CP_CTRL        = 4'hf;
    localparam int          CTL_W          = 6;
    localparam logic [5:0]  CTL_RST        = 6'h00;
    localparam int          CTL_MMU        = 0;
    localparam int          CTL_ALIGN      = 1;
    localparam int          CTL_DCACHE     = 2;
    localparam int          CTL_WBUF       = 3;
    localparam int          CTL_ICACHE     = 4;
    localparam int          CTL_BIGEND     = 5;
    localparam int          NUM_BANKS      = 5;

    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_DABT = 3'h1,
        EXC_FAST = 3'h2,
        EXC_IRQ  = 3'h3,
        EXC_PABT = 3'h4,
        EXC_UND  = 3'h5,
        EXC_SWI  = 3'h6
    } eesq_exc_t;

    typedef enum logic [2:0] {
        BANK_SVC = 3'h0,
        BANK_ABT = 3'h1,
        BANK_UND = 3'h2,
        BANK_IRQ = 3'h3,
        BANK_FAST = 3'h4
    } eesq_bank_t;

    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_RUN   = 2'h1,
        ST_CHAIN = 2'h2
    } eesq_state_t;
endpackage : eesq_pkg

// file: eesq_top.sv
// Exception entry sequencer: reset, aborts, vectors, banked save
`timescale 1ns/1ps
module eesq_top
    import eesq_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        ext_abort_i,
    input  wire logic        fast_interrupt_i,
    input  wire logic        irq_i,
    input  wire logic        mmu_abort_i,
    input  wire logic        fetch_access_i,
    input  wire logic        data_access_i,
    input  wire logic        instr_issue_i,
    input  wire logic        flush_i,
    input  wire logic        boundary_i,
    input  wire logic [31:0] instr_i,
    input  wire logic        undef_i,
    input  wire logic [31:0] pc_i,
    input  wire logic        is_block_i,
    input  wire logic        base_in_list_i,
    input  wire logic        status_wr_i,
    input  wire logic [31:0] status_wdata_i,
    input  wire logic        ctl_wr_i,
    input  wire logic [5:0]  ctl_wdata_i,
    input  wire logic [2:0]  bank_sel_i,
    output logic             reset_output_low_o,
    output logic             bus_enable_o,
    output logic             redirect_o,
    output logic [31:0]      redirect_addr_o,
    output logic             squash_o,
    output logic             no_base_wb_o,
    output logic             restore_base_o,
    output logic [31:0]      current_status_word_o,
    output logic [31:0]      bank_link_o,
    output logic [31:0]      bank_status_o,
    output logic             mmu_enable_o,
    output logic             align_enable_o,
    output logic             dcache_enable_o,
    output logic             wbuf_enable_o,
    output logic             icache_enable_o,
    output logic             big_endian_o
);
    eesq_exc_if exc ();

    eesq_state_t state_reg;
    logic [2:0]  meta_reg;
    logic [2:0]  sync_reg;
    logic        ext_abort_s;
    logic        fast_s;
    logic        irq_s;
    logic [31:0] status_reg;
    logic [5:0]  ctl_reg;
    logic        rst_out_reg;
    logic        fetch_tag_reg;
    logic        exec_tag_reg;
    logic        redirect_reg;
    logic [31:0] redirect_addr_reg;
    logic        squash_reg;
    logic        no_wb_reg;
    logic        restore_reg;
    logic [31:0] link_mem [NUM_BANKS];
    logic [31:0] stat_mem [NUM_BANKS];
    logic [31:0] bank_link_reg;
    logic [31:0] bank_stat_reg;
    logic        abort_now;
    logic        release_now;
    logic        entry;
    eesq_bank_t  bank_sel;
    logic [4:0]  mode_next;
    logic [31:0] vec_next;
    logic [31:0] link_next;

    eesq_arb eesq_arb_inst (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .exc       (exc.arb)
    );

    // Pin inputs pass two flops before use
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end else begin
            meta_reg <= {ext_abort_i, fast_interrupt_i, irq_i};
            sync_reg <= meta_reg;
        end
    end

    assign ext_abort_s = sync_reg[2];
    assign fast_s      = sync_reg[1];
    assign irq_s       = sync_reg[0];
    assign abort_now   = mmu_abort_i || ext_abort_s;
    assign release_now = (state_reg == ST_RESET);
    assign entry       = (state_reg != ST_RESET) && (exc.win != EXC_NONE);

    assign exc.dabt     = (state_reg != ST_RESET) && data_access_i && abort_now;
    assign exc.fast     = fast_s && !status_reg[ST_F_BIT];
    assign exc.irq      = irq_s && !status_reg[ST_I_BIT];
    assign exc.pabt     = exec_tag_reg;
    assign exc.boundary = (state_reg == ST_RUN) && boundary_i;
    assign exc.chain    = (state_reg == ST_CHAIN);
    assign exc.undef    = undef_i;
    assign exc.instr    = instr_i;
    assign exc.mode     = status_reg[4:0];

    always_comb begin
        bank_sel  = BANK_SVC;
        mode_next = MODE_SVC;
        vec_next  = VEC_RST;
        link_next = pc_i + LINK_OFS_OTHER;
        case (exc.win)
            EXC_DABT: begin
                bank_sel  = BANK_ABT;
                mode_next = MODE_ABT;
                vec_next  = VEC_DABT;
                link_next = pc_i + LINK_OFS_DABT;
            end
            EXC_PABT: begin
                bank_sel  = BANK_ABT;
                mode_next = MODE_ABT;
                vec_next  = VEC_PABT;
                link_next = pc_i + LINK_OFS_PABT;
            end
            EXC_FAST: begin
                bank_sel  = BANK_FAST;
                mode_next = MODE_FAST;
                vec_next  = VEC_FAST;
                // Chained entry returns into the abort handler
                link_next = (state_reg == ST_CHAIN) ? redirect_addr_reg + LINK_OFS_OTHER
                                                    : pc_i + LINK_OFS_OTHER;
            end
            EXC_IRQ: begin
                bank_sel  = BANK_IRQ;
                mode_next = MODE_IRQ;
                vec_next  = VEC_IRQ;
            end
            EXC_UND: begin
                bank_sel  = BANK_UND;
                mode_next = MODE_UND;
                vec_next  = VEC_UND;
            end
            EXC_SWI: begin
                bank_sel  = BANK_SVC;
                mode_next = MODE_SVC;
                vec_next  = VEC_SWI;
            end
            default: begin
                bank_sel  = BANK_SVC;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_RESET;
        end else begin
            case (state_reg)
                ST_RESET: state_reg <= ST_RUN;
                ST_RUN:   state_reg <= (exc.win == EXC_DABT) ? ST_CHAIN : ST_RUN;
                ST_CHAIN: state_reg <= (exc.win == EXC_DABT) ? ST_CHAIN : ST_RUN;
                default:  state_reg <= ST_RESET;
            endcase
        end
    end

    // Reset out and bus idle follow the reset input
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rst_out_reg <= 1'b0;
        end else begin
            rst_out_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            status_reg <= STATUS_RST;
        end else if (release_now) begin
            status_reg[4:0]      <= MODE_SVC;
            status_reg[ST_I_BIT] <= 1'b1;
            status_reg[ST_F_BIT] <= 1'b1;
        end else if (entry) begin
            status_reg[4:0]      <= mode_next;
            status_reg[ST_I_BIT] <= 1'b1;
            if (exc.win == EXC_FAST) begin
                status_reg[ST_F_BIT] <= 1'b1;
            end
        end else if (status_wr_i) begin
            status_reg <= status_wdata_i;
        end
    end

    // Banked save; a 26-bit caller gets a plain PC, no flags merged
    always_ff @(posedge mclk_i) begin
        if (reset_n_i && release_now) begin
            link_mem[BANK_SVC] <= pc_i;
            stat_mem[BANK_SVC] <= status_reg;
        end else if (reset_n_i && entry) begin
            link_mem[bank_sel] <= link_next;
            stat_mem[bank_sel] <= status_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            bank_link_reg <= 32'h0000_0000;
            bank_stat_reg <= 32'h0000_0000;
        end else if (bank_sel_i < 3'(NUM_BANKS)) begin
            bank_link_reg <= link_mem[bank_sel_i];
            bank_stat_reg <= stat_mem[bank_sel_i];
        end else begin
            bank_link_reg <= 32'h0000_0000;
            bank_stat_reg <= 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            redirect_reg      <= 1'b0;
            redirect_addr_reg <= VEC_RST;
        end else if (release_now) begin
            redirect_reg      <= 1'b1;
            redirect_addr_reg <= VEC_RST;
        end else if (entry) begin
            redirect_reg      <= 1'b1;
            redirect_addr_reg <= vec_next;
        end else begin
            redirect_reg      <= 1'b0;
        end
    end

    // Data abort cancels register writes of the faulting instruction
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            squash_reg  <= 1'b0;
            no_wb_reg   <= 1'b0;
            restore_reg <= 1'b0;
        end else begin
            squash_reg  <= exc.dabt;
            no_wb_reg   <= exc.dabt && is_block_i;
            restore_reg <= exc.dabt && is_block_i && base_in_list_i;
        end
    end

    // Prefetch abort only tags; raised if the instruction executes
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || flush_i || entry) begin
            fetch_tag_reg <= 1'b0;
            exec_tag_reg  <= 1'b0;
        end else begin
            if (fetch_access_i) begin
                fetch_tag_reg <= abort_now;
            end
            if (instr_issue_i) begin
                exec_tag_reg <= fetch_tag_reg;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ctl_reg <= CTL_RST;
        end else if (release_now) begin
            ctl_reg <= CTL_RST;
        end else if (ctl_wr_i) begin
            ctl_reg <= ctl_wdata_i;
        end
    end

    assign reset_output_low_o    = rst_out_reg;
    assign bus_enable_o          = rst_out_reg;
    assign redirect_o            = redirect_reg;
    assign redirect_addr_o       = redirect_addr_reg;
    assign squash_o              = squash_reg;
    assign no_base_wb_o          = no_wb_reg;
    assign restore_base_o        = restore_reg;
    assign current_status_word_o = status_reg;
    assign bank_link_o           = bank_link_reg;
    assign bank_status_o         = bank_stat_reg;
    assign mmu_enable_o          = ctl_reg[CTL_MMU];
    assign align_enable_o        = ctl_reg[CTL_ALIGN];
    assign dcache_enable_o       = ctl_reg[CTL_DCACHE];
    assign wbuf_enable_o         = ctl_reg[CTL_WBUF];
    assign icache_enable_o       = ctl_reg[CTL_ICACHE];
    assign big_endian_o          = ctl_reg[CTL_BIGEND];

    a_reset_idle: assert property (@(posedge mclk_i)
        !reset_n_i |=> !reset_output_low_o && !bus_enable_o)
        else $error("reset output not asserted");
    a_release_mode: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        release_now |=> status_reg[4:0] == MODE_SVC && status_reg[ST_I_BIT] && status_reg[ST_F_BIT])
        else $error("release mode wrong");
    a_release_fetch: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        release_now |=> redirect_o && redirect_addr_o == VEC_RST)
        else $error("release fetch not from zero");
    a_release_ctl: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        release_now |=> ctl_reg == CTL_RST)
        else $error("control bits not cleared");
    a_dabt_entry: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        exc.dabt |=> redirect_addr_o == VEC_DABT && status_reg[4:0] == MODE_ABT && squash_o)
        else $error("data abort entry wrong");
    a_pabt_link: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        entry && exc.win == EXC_PABT |=> link_mem[BANK_ABT] == $past(pc_i) + LINK_OFS_PABT)
        else $error("prefetch abort link wrong");
    a_fast_chain: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        exc.chain && exc.fast && !exc.dabt |-> exc.win == EXC_FAST)
        else $error("chained fast interrupt missed");
    a_irq_masked: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        exc.win == EXC_IRQ |-> !status_reg[ST_I_BIT] && boundary_i)
        else $error("masked interrupt taken");
    a_entry_32bit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        entry |=> status_reg[ST_M32_BIT] && redirect_o)
        else $error("entry not in 32-bit mode");
endmodule : eesq_top

// file: exception_entry_sequencer_tb.sv
// Self-checking bench for the exception entry sequencer
`timescale 1ns/1ps
module exception_entry_sequencer_tb
    import eesq_pkg::*;
;
    typedef struct {
        logic [31:0] st;
        logic [31:0] ins;
        logic [3:0]  fl;
        logic [31:0] vec;
        logic [4:0]  md;
        eesq_bank_t  bk;
    } eesq_row_t;
    localparam logic [31:0] USR = 32'h0000_0010;
    localparam logic [31:0] SVC = 32'h0000_0013;
    localparam logic [31:0] NOP = 32'he1a0_0000;
    localparam logic [31:0] SWI = 32'hef00_0000;
    localparam logic [31:0] PC  = 32'h0000_1000;
    logic        mclk_i, reset_n_i, ext_abort_i, fast_interrupt_i, irq_i, mmu_abort_i;
    logic        fetch_access_i, data_access_i, instr_issue_i, flush_i, boundary_i, undef_i;
    logic        is_block_i, base_in_list_i, status_wr_i, ctl_wr_i;
    logic [31:0] instr_i, pc_i, status_wdata_i;
    logic [5:0]  ctl_wdata_i;
    logic [2:0]  bank_sel_i;
    logic        reset_output_low_o, bus_enable_o, redirect_o, squash_o, no_base_wb_o, restore_base_o;
    logic        mmu_enable_o, align_enable_o, dcache_enable_o, wbuf_enable_o, icache_enable_o, big_endian_o;
    logic [31:0] redirect_addr_o, current_status_word_o, bank_link_o, bank_status_o, fetch_addr, ctl_bits, got;
    logic        hit;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    eesq_row_t   rows [16];

    assign ctl_bits = {26'h0, big_endian_o, icache_enable_o, wbuf_enable_o,
                       dcache_enable_o, align_enable_o, mmu_enable_o};

    eesq_top eesq_top_inst (
        .mclk_i, .reset_n_i, .ext_abort_i, .fast_interrupt_i, .irq_i, .mmu_abort_i, .fetch_access_i,
        .data_access_i, .instr_issue_i, .flush_i, .boundary_i, .instr_i, .undef_i, .pc_i, .is_block_i,
        .base_in_list_i, .status_wr_i, .status_wdata_i, .ctl_wr_i, .ctl_wdata_i, .bank_sel_i,
        .reset_output_low_o, .bus_enable_o, .redirect_o, .redirect_addr_o, .squash_o, .no_base_wb_o,
        .restore_base_o, .current_status_word_o, .bank_link_o, .bank_status_o, .mmu_enable_o,
        .align_enable_o, .dcache_enable_o, .wbuf_enable_o, .icache_enable_o, .big_endian_o
    );

    eesq_fetch_model eesq_fetch_model_inst (
        .mclk_i          (mclk_i),
        .reset_n_i       (reset_n_i),
        .redirect_i      (redirect_o),
        .redirect_addr_i (redirect_addr_o),
        .bus_enable_i    (bus_enable_o),
        .fetch_addr_o    (fetch_addr)
    );

    always #12.5 mclk_i = ~mclk_i;

    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc > 5000) begin
            err_total = err_total + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic chk1(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk32

    // Mode field and normal interrupt mask after an entry
    task automatic chk_mode(input logic [4:0] md);
        chk32("mode and mask", {26'h0, 1'h1, md}, {26'h0, current_status_word_o[7], current_status_word_o[4:0]});
    endtask : chk_mode

    // Polls the redirect pulse for a bounded number of cycles
    task automatic catch_entry(input logic take, input logic [31:0] vec);
        hit = 1'b0;
        for (int k = 0; k < 7 && hit !== 1'b1; k++) begin
            @(negedge mclk_i);
            if (redirect_o === 1'b1) begin
                hit = 1'b1;
                got = redirect_addr_o;
            end
        end
        chk1("redirect", take, hit);
        if (take) chk32("vector", vec, got);
    endtask : catch_entry

    task automatic clear_in();
        @(posedge mclk_i);
        {ext_abort_i, fast_interrupt_i, irq_i, mmu_abort_i, fetch_access_i, data_access_i} <= '0;
        {instr_issue_i, flush_i, boundary_i, undef_i, is_block_i, base_in_list_i, status_wr_i} <= '0;
        instr_i <= NOP;
        repeat (4) @(posedge mclk_i);
    endtask : clear_in

    task automatic set_st(input logic [31:0] s);
        @(posedge mclk_i);
        status_wr_i <= 1'b1;
        status_wdata_i <= s;
        @(posedge mclk_i);
        status_wr_i <= 1'b0;
    endtask : set_st

    task automatic chk_bank(input eesq_bank_t b, input logic [31:0] l, input logic [31:0] s);
        @(posedge mclk_i);
        bank_sel_i <= b;
        @(posedge mclk_i);
        @(negedge mclk_i);
        chk32("bank link", l, bank_link_o);
        chk32("bank status", s, bank_status_o);
    endtask : chk_bank

    task automatic do_reset();
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        chk1("reset out", 1'h0, reset_output_low_o);
        chk1("bus enable", 1'h0, bus_enable_o);
        @(posedge mclk_i);
        reset_n_i <= 1'b1;
        catch_entry(1'h1, VEC_RST);
        chk32("status", STATUS_RST, current_status_word_o);
        chk1("reset out", 1'h1, reset_output_low_o);
        @(posedge mclk_i);
        @(negedge mclk_i);
        chk32("first fetch", VEC_RST, fetch_addr);
    endtask : do_reset

    task automatic pabt(input logic fl);
        set_st(USR);
        {fetch_access_i, mmu_abort_i} <= 2'h3;
        @(posedge mclk_i);
        {fetch_access_i, mmu_abort_i, instr_issue_i} <= 3'h1;
        @(posedge mclk_i);
        {instr_issue_i, flush_i} <= {1'h0, fl};
        @(posedge mclk_i);
        {flush_i, boundary_i} <= 2'h1;
        @(posedge mclk_i);
        boundary_i <= 1'b0;
        catch_entry(!fl, VEC_PABT);
        if (!fl) begin
            chk_mode(MODE_ABT);
            chk1("fast mask kept", 1'h0, current_status_word_o[6]);
            clear_in();
            chk_bank(BANK_ABT, PC + 32'h4, USR);
        end
        $display("test prefetch abort flush=%b done", fl);
    endtask : pabt

    task automatic dabt(input logic blk, input logic pin);
        set_st(USR);
        {is_block_i, base_in_list_i, ext_abort_i} <= {blk, blk, pin};
        if (pin) repeat (2) @(posedge mclk_i);
        {data_access_i, mmu_abort_i} <= {1'h1, !pin};
        @(posedge mclk_i);
        {data_access_i, mmu_abort_i, ext_abort_i} <= 3'h0;
        catch_entry(1'h1, VEC_DABT);
        chk_mode(MODE_ABT);
        if (!blk) chk1("squash", 1'h1, squash_o);
        chk1("no base writeback", blk, no_base_wb_o);
        chk1("restore base", blk, restore_base_o);
        clear_in();
        chk_bank(BANK_ABT, PC + 32'h8, USR);
        $display("test data abort block=%b pin=%b done", blk, pin);
    endtask : dabt

    initial begin
        {mclk_i, reset_n_i, ext_abort_i, fast_interrupt_i, irq_i, mmu_abort_i, fetch_access_i} = '0;
        {data_access_i, instr_issue_i, flush_i, boundary_i, undef_i, is_block_i} = '0;
        {base_in_list_i, status_wr_i, ctl_wr_i, ctl_wdata_i, bank_sel_i, status_wdata_i} = '0;
        instr_i = NOP;
        pc_i = PC;
        rows = '{
            '{USR, NOP, 4'h9, VEC_UND, MODE_UND, BANK_UND}, '{USR, SWI, 4'h1, VEC_SWI, MODE_SVC, BANK_SVC},
            '{SVC, 32'hee10_0e10, 4'h1, VEC_UND, MODE_UND, BANK_UND},
            '{SVC, 32'hee00_0f00, 4'h1, VEC_UND, MODE_UND, BANK_UND},
            '{SVC, 32'hed90_0f00, 4'h1, VEC_UND, MODE_UND, BANK_UND},
            '{SVC, 32'hed80_0f00, 4'h1, VEC_UND, MODE_UND, BANK_UND},
            '{USR, 32'hee10_0f10, 4'h1, VEC_UND, MODE_UND, BANK_UND},
            '{SVC, 32'hee10_0f10, 4'h0, VEC_UND, MODE_UND, BANK_UND},
            '{USR, NOP, 4'h5, VEC_IRQ, MODE_IRQ, BANK_IRQ}, '{USR, NOP, 4'h3, VEC_FAST, MODE_FAST, BANK_FAST},
            '{USR, SWI, 4'h7, VEC_FAST, MODE_FAST, BANK_FAST}, '{USR, SWI, 4'h5, VEC_IRQ, MODE_IRQ, BANK_IRQ},
            '{32'h0000_0090, NOP, 4'h4, VEC_IRQ, MODE_IRQ, BANK_IRQ},
            '{32'h0000_0050, NOP, 4'h2, VEC_FAST, MODE_FAST, BANK_FAST},
            '{32'h0000_0000, 32'hee10_0f10, 4'h1, VEC_UND, MODE_UND, BANK_UND},
            '{32'h0000_0000, SWI, 4'h1, VEC_SWI, MODE_SVC, BANK_SVC}};
        do_reset();
        @(posedge mclk_i);
        {ctl_wr_i, ctl_wdata_i} <= 7'h7f;
        @(posedge mclk_i);
        ctl_wr_i <= 1'b0;
        @(negedge mclk_i);
        chk32("controls set", 32'h3f, ctl_bits);
        do_reset();
        chk32("controls after reset", 32'h0, ctl_bits);
        chk_bank(BANK_SVC, PC, STATUS_RST);
        $display("test reset done");
        foreach (rows[r]) begin
            @(posedge mclk_i);
            {irq_i, fast_interrupt_i} <= rows[r].fl[2:1];
            set_st(rows[r].st);
            repeat (3) @(posedge mclk_i);
            {instr_i, undef_i, boundary_i} <= {rows[r].ins, rows[r].fl[3], 1'h1};
            @(posedge mclk_i);
            {undef_i, boundary_i} <= 2'h0;
            catch_entry(rows[r].fl[0], rows[r].vec);
            if (rows[r].fl[0]) chk_mode(rows[r].md);
            clear_in();
            if (rows[r].fl[0]) chk_bank(rows[r].bk, PC + 32'h4, rows[r].st);
        end
        $display("test vector rows done");
        pabt(1'h0);
        pabt(1'h1);
        dabt(1'h0, 1'h0);
        dabt(1'h1, 1'h0);
        dabt(1'h0, 1'h1);
        @(posedge mclk_i);
        fast_interrupt_i <= 1'b1;
        set_st(USR);
        repeat (3) @(posedge mclk_i);
        {data_access_i, mmu_abort_i} <= 2'h3;
        @(posedge mclk_i);
        {data_access_i, mmu_abort_i} <= 2'h0;
        catch_entry(1'h1, VEC_DABT);
        catch_entry(1'h1, VEC_FAST);
        chk_mode(MODE_FAST);
        clear_in();
        chk_bank(BANK_FAST, VEC_DABT + 32'h4, 32'h0000_0097);
        $display("test abort then fast interrupt done");
        give_verdict();
    end
endmodule : exception_entry_sequencer_tb
